/* File: pmc_cfg_if.sv */
// carrier between the register bank and the pin driver of one port
`timescale 1ns/1ps
interface pmc_cfg_if;
    import pmc_pkg::*;
    logic wr;
    logic [2:0] sel;
    logic [7:0] wdata;
    pmc_cfg_t cfg;
    modport regs (input wr, input sel, input wdata, output cfg);
    modport pins (input cfg);
endinterface : pmc_cfg_if

/* File: pmc_host_model.sv */
// host side of the f and g data lines
`timescale 1ns/1ps
module pmc_host_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic host_drive_in,
    input wire logic [15:0] host_val_in,
    input wire logic [15:0] dev_val_in,
    input wire logic [15:0] dev_oe_n_in,
    output logic [15:0] lines_out,
    output logic [15:0] boot_cfg_out
);
    logic [15:0] last_r = 16'h0000;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (!dev_oe_n_in[i]) begin
                lines_out[i] = dev_val_in[i];
            end else if (host_drive_in) begin
                lines_out[i] = host_val_in[i];
            end else begin
                lines_out[i] = ~last_r[i];
            end
        end
    end
    always @(posedge clk_in) begin
        last_r <= lines_out;
        if (rst_in) begin
            boot_cfg_out <= lines_out;
        end
    end
endmodule : pmc_host_model

/* File: pmc_pin_drv.sv */
// pin output selection and drive style for one port
`timescale 1ns/1ps
module pmc_pin_drv #(
    parameter logic OPEN_DRAIN_OK = 1'b0,
    parameter logic SLEW_OK = 1'b0
) (
    pmc_cfg_if.pins bus,
    input wire logic [7:0] pld_sel_in,
    input wire logic [7:0] pld_val_in,
    input wire logic [7:0] pld_oe_in,
    input wire logic [7:0] alt_en_in,
    input wire logic [7:0] alt_val_in,
    input wire logic [7:0] force_en_in,
    input wire logic [7:0] force_oe_in,
    input wire logic [7:0] force_val_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n_out,
    output logic [7:0] fast_slew_out
);
    import pmc_pkg::*;

    logic [7:0] gp_en;
    logic [7:0] gp_val;
    logic [7:0] drive;
    logic [7:0] value;
    logic [7:0] od;

    always_comb begin
        // data register reaches the pin on direction or logic enable
        gp_en = (pld_sel_in & pld_oe_in) | (~pld_sel_in & (bus.cfg.direction | pld_oe_in));
        gp_val = (pld_sel_in & pld_val_in) | (~pld_sel_in & bus.cfg.data_out);
        drive = (force_en_in & force_oe_in) | (~force_en_in & (alt_en_in | gp_en));
        value = (force_en_in & force_val_in)
            | (~force_en_in & alt_en_in & alt_val_in)
            | (~force_en_in & ~alt_en_in & gp_val);
        od = OPEN_DRAIN_OK ? (bus.cfg.drive_select & ~force_en_in) : MASK_NONE;
        pin_out = value & ~od;
        pin_oe_n_out = ~(drive & (~od | ~value));
        fast_slew_out = SLEW_OK ? bus.cfg.drive_select : MASK_NONE;
    end
endmodule : pmc_pin_drv

/* File: pmc_pkg.sv */
// constants and types shared by the port configuration logic
package pmc_pkg;
    localparam int NPORT = 7;
    localparam int PW = 8;
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;
    localparam int PORT_G = 6;

    // register index inside a port slot
    localparam logic [2:0] REG_DATA_IN = 3'h0;
    localparam logic [2:0] REG_DATA_OUT = 3'h1;
    localparam logic [2:0] REG_DIRECTION = 3'h2;
    localparam logic [2:0] REG_DRIVE_SELECT = 3'h3;
    localparam logic [2:0] REG_MODE_SELECT = 3'h4;
    // offset field positions: offset = port * 8 + register index
    localparam int OFS_REG_LSB = 0;
    localparam int OFS_PORT_LSB = 3;
    localparam int OFS_TOP_LSB = 6;
    localparam logic [1:0] OFS_TOP_ZERO = 2'h0;

    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_NIBBLE = 8'h0f;
    localparam logic [7:0] MASK_NONE = 8'h00;
    localparam logic [7:0] LOW_NIBBLE = 8'h0f;

    // per-port feature maps, bit n = port n (A = bit 0)
    localparam logic [NPORT-1:0] HAS_MODE = 7'h70;
    localparam logic [NPORT-1:0] OPEN_DRAIN_PORTS = 7'h5b;
    localparam logic [NPORT-1:0] SLEW_PORTS = 7'h24;
    localparam logic [NPORT-1:0] ADDR_IN_PORTS = 7'h2f;

    typedef struct packed {
        logic [PW-1:0] data_out;
        logic [PW-1:0] direction;
        logic [PW-1:0] drive_select;
        logic [PW-1:0] mode_select;
    } pmc_cfg_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic [15:0] addr_latch;
        logic [NPORT-1:0][PW-1:0] high_addr;
        logic [NPORT-1:0][PW-1:0] pld_pins;
        logic [15:0] data_lines;
    } pmc_top_state_t;
endpackage : pmc_pkg

/* File: pmc_port_properties.sv */
// assertions on the ports of the seven-port configuration top
`timescale 1ns/1ps
module pmc_port_properties (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic io_register_space_in,
    input wire logic host_rd_in,
    input wire logic host_wr_in,
    input wire logic [7:0] host_addr_in,
    input wire logic [7:0] host_wdata_in,
    input wire logic [7:0] host_rdata_out,
    input wire logic address_latch_strobe_in,
    input wire logic host_data_drive_in,
    input wire logic [15:0] host_data_lines_out,
    input wire logic cfg_data_port_in,
    input wire logic cfg_reset_mode_in,
    input wire logic [15:0] cfg_reset_pattern_in,
    input wire logic [pmc_pkg::NPORT-1:0][7:0] cfg_pld_out_sel_in,
    input wire logic [pmc_pkg::NPORT-1:0][7:0] pld_oe_in,
    input wire logic [pmc_pkg::NPORT-1:0][7:0] high_addr_out,
    input wire logic [7:0] jtag_sel_in,
    input wire logic [7:0] jtag_pins_out,
    input wire logic [pmc_pkg::NPORT-1:0][7:0] pin_in,
    input wire logic [pmc_pkg::NPORT-1:0][7:0] pin_out,
    input wire logic [pmc_pkg::NPORT-1:0][7:0] pin_oe_n_out,
    input wire logic [pmc_pkg::NPORT-1:0][7:0] pin_fast_slew_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    a_read_back_dir: assert property (
        io_register_space_in && host_wr_in && host_addr_in == 8'h22 ##1 !host_wr_in
        ##1 io_register_space_in && host_rd_in && !host_wr_in && host_addr_in == 8'h22
        |=> host_rdata_out == $past(host_wdata_in, 3)) else $error("read back mismatch");
    a_unmapped_zero: assert property (
        io_register_space_in && host_rd_in && host_addr_in[7:6] != 2'h0
        |=> host_rdata_out == 8'h00) else $error("unmapped read not zero");
    a_dir_drives_pin: assert property (
        io_register_space_in && host_wr_in && host_addr_in == 8'h12 |=> cfg_pld_out_sel_in[2] != 8'h00
        || pin_oe_n_out[2] == ~($past(host_wdata_in) | pld_oe_in[2])) else $error("c enable wrong");
    a_port_d_upper: assert property (
        pin_oe_n_out[3][7:4] == 4'hf) else $error("port d upper pins driven");
    a_slew_ports: assert property (
        {pin_fast_slew_out[6], pin_fast_slew_out[4:3], pin_fast_slew_out[1:0]} == 40'h0)
        else $error("slew on open drain port");
    a_reset_pattern: assert property (
        disable iff (1'b0) rst_in && cfg_reset_mode_in && !host_rd_in && !host_wr_in
        |-> {pin_out[6], pin_out[5]} == cfg_reset_pattern_in
        && {pin_oe_n_out[6], pin_oe_n_out[5]} == 16'h0000) else $error("reset pattern absent");
    a_data_sample: assert property (
        cfg_data_port_in |=> host_data_lines_out == $past({pin_in[6], pin_in[5]}))
        else $error("data port sample wrong");
    a_data_no_gpio: assert property (
        cfg_data_port_in && !host_data_drive_in |-> pin_oe_n_out[5] == 8'hff
        && pin_oe_n_out[6] == 8'hff) else $error("data port pins driven");
    a_jtag_input: assert property (
        jtag_pins_out == (pin_in[4] & jtag_sel_in)) else $error("jtag input wrong");
    a_high_addr_cap: assert property (
        address_latch_strobe_in |=> high_addr_out[0] == $past(pin_in[0])
        && high_addr_out[4] == 8'h00) else $error("high address capture wrong");
endmodule : pmc_port_properties

bind pmc_port_top pmc_port_properties pmc_port_properties_inst (.*);

/* File: pmc_port_regs.sv */
// configuration and output data registers of one port
`timescale 1ns/1ps
module pmc_port_regs #(
    parameter logic [7:0] MASK = 8'hff,
    parameter logic HAS_MODE_REG = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    pmc_cfg_if.regs bus
);
    import pmc_pkg::*;

    pmc_cfg_t state_r;
    pmc_cfg_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        if (bus.wr) begin
            case (bus.sel)
                REG_DATA_OUT: state_nxt.data_out = bus.wdata & MASK;
                REG_DIRECTION: state_nxt.direction = bus.wdata & MASK;
                REG_DRIVE_SELECT: state_nxt.drive_select = bus.wdata & MASK;
                REG_MODE_SELECT: begin
                    state_nxt.mode_select = HAS_MODE_REG ? bus.wdata : CFG_RESET;
                end
                default: state_nxt = state_r;
            endcase
        end
    end

    // power-up clear, write visible from the following edge
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= {4{CFG_RESET}};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign bus.cfg = state_r;
endmodule : pmc_port_regs

/* File: pmc_port_top.sv */
// seven-port pin configuration logic with host register access
`timescale 1ns/1ps
module pmc_port_top (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // host register access in the io_register_space
    input wire logic io_register_space_in,
    input wire logic host_rd_in,
    input wire logic host_wr_in,
    input wire logic [7:0] host_addr_in,
    input wire logic [7:0] host_wdata_in,
    output logic [7:0] host_rdata_out,
    // multiplexed address/data and strobe for latched address
    input wire logic [15:0] host_ad_in,
    input wire logic address_latch_strobe_in,
    // non-multiplexed data port on f and g
    input wire logic host_data_drive_in,
    input wire logic [15:0] host_data_wr_in,
    output logic [15:0] host_data_lines_out,
    // fixed device configuration
    input wire logic cfg_narrow_addr_in,
    input wire logic cfg_data_port_in,
    input wire logic cfg_reset_mode_in,
    input wire logic [15:0] cfg_reset_pattern_in,
    input wire logic [pmc_pkg::NPORT-1:0][7:0] cfg_pld_out_sel_in,
    // logic array outputs and enables
    input wire logic [pmc_pkg::NPORT-1:0][7:0] pld_val_in,
    input wire logic [pmc_pkg::NPORT-1:0][7:0] pld_oe_in,
    output logic [pmc_pkg::NPORT-1:0][7:0] pld_pins_out,
    output logic [pmc_pkg::NPORT-1:0][7:0] high_addr_out,
    // jtag use of port e
    input wire logic [7:0] jtag_sel_in,
    input wire logic [7:0] jtag_val_in,
    input wire logic [7:0] jtag_oe_in,
    output logic [7:0] jtag_pins_out,
    // port pins
    input wire logic [pmc_pkg::NPORT-1:0][7:0] pin_in,
    output logic [pmc_pkg::NPORT-1:0][7:0] pin_out,
    output logic [pmc_pkg::NPORT-1:0][7:0] pin_oe_n_out,
    output logic [pmc_pkg::NPORT-1:0][7:0] pin_fast_slew_out
);
    import pmc_pkg::*;

    pmc_top_state_t state_r;
    pmc_top_state_t state_nxt;

    pmc_cfg_t cfg_a [NPORT];
    logic [NPORT-1:0][7:0] alt_en;
    logic [NPORT-1:0][7:0] alt_val;
    logic [NPORT-1:0][7:0] force_en;
    logic [NPORT-1:0][7:0] force_oe;
    logic [NPORT-1:0][7:0] force_val;
    logic [NPORT-1:0][7:0] pld_sel;
    logic [NPORT-1:0][7:0] pld_oe_m;

    logic [2:0] reg_idx;
    logic [2:0] port_idx;
    logic addr_ok;
    logic wr_hit;
    logic rd_hit;
    logic bus_cycle;
    logic pattern_on;
    logic data_port_on;
    logic [7:0] addr_low;
    logic [7:0] addr_high;
    logic [7:0] addr_valid_ef;

    // register decode
    always_comb begin
        reg_idx = host_addr_in[OFS_REG_LSB +: 3];
        port_idx = host_addr_in[OFS_PORT_LSB +: 3];
        addr_ok = (host_addr_in[OFS_TOP_LSB +: 2] == OFS_TOP_ZERO)
            && (port_idx < 3'(NPORT))
            && (reg_idx <= REG_MODE_SELECT);
        wr_hit = io_register_space_in && host_wr_in && addr_ok;
        rd_hit = io_register_space_in && host_rd_in;
        bus_cycle = host_rd_in || host_wr_in;
    end

    // reset pattern only while reset holds and the bus is idle
    always_comb begin
        pattern_on = cfg_reset_mode_in && rst_in && !bus_cycle;
        data_port_on = cfg_data_port_in && !pattern_on;
    end

    // latched address sources
    always_comb begin
        addr_low = state_r.addr_latch[7:0];
        addr_high = state_r.addr_latch[15:8];
        addr_valid_ef = cfg_narrow_addr_in ? ~LOW_NIBBLE : MASK_FULL;
    end

    // logic outputs only on a, b, c; port d upper pins never drive
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            pld_sel[p] = MASK_NONE;
            pld_oe_m[p] = pld_oe_in[p];
            if (p <= PORT_C) begin
                pld_sel[p] = cfg_pld_out_sel_in[p];
            end
            if (p == PORT_D) begin
                pld_oe_m[p] = pld_oe_in[p] & MASK_NIBBLE;
            end
        end
    end

    // per-port override and alternate sources
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            alt_en[p] = MASK_NONE;
            alt_val[p] = MASK_NONE;
            force_en[p] = MASK_NONE;
            force_oe[p] = MASK_NONE;
            force_val[p] = MASK_NONE;
            if (HAS_MODE[p]) begin
                // address needs mode plus direction or logic enable
                alt_en[p] = cfg_a[p].mode_select
                    & (cfg_a[p].direction | pld_oe_in[p]);
                alt_val[p] = (p == PORT_G) ? addr_high : addr_low;
                if (p != PORT_G) begin
                    alt_en[p] = alt_en[p] & addr_valid_ef;
                end
            end
        end
        // jtag takes port e pins away from general use
        force_en[PORT_E] = jtag_sel_in;
        force_oe[PORT_E] = jtag_oe_in & jtag_sel_in;
        force_val[PORT_E] = jtag_val_in;
        if (pattern_on) begin
            force_en[PORT_F] = MASK_FULL;
            force_en[PORT_G] = MASK_FULL;
            force_oe[PORT_F] = MASK_FULL;
            force_oe[PORT_G] = MASK_FULL;
            force_val[PORT_F] = cfg_reset_pattern_in[7:0];
            force_val[PORT_G] = cfg_reset_pattern_in[15:8];
        end else if (data_port_on) begin
            force_en[PORT_F] = MASK_FULL;
            force_en[PORT_G] = MASK_FULL;
            force_oe[PORT_F] = {8{host_data_drive_in}};
            force_oe[PORT_G] = {8{host_data_drive_in}};
            force_val[PORT_F] = host_data_wr_in[7:0];
            force_val[PORT_G] = host_data_wr_in[15:8];
        end
    end

    // register banks and pin drivers, one per port
    for (genvar g = 0; g < NPORT; g++) begin : g_port
        pmc_cfg_if cfg_bus ();

        assign cfg_bus.wr = wr_hit && (port_idx == 3'(g));
        assign cfg_bus.sel = reg_idx;
        assign cfg_bus.wdata = host_wdata_in;
        assign cfg_a[g] = cfg_bus.cfg;

        pmc_port_regs #(
            .MASK((g == PORT_D) ? MASK_NIBBLE : MASK_FULL),
            .HAS_MODE_REG(HAS_MODE[g])
        ) u_regs (
            .sys_clk_in(sys_clk_in),
            .rst_in(rst_in),
            .bus(cfg_bus.regs)
        );

        // each register bit steers only its own pin
        pmc_pin_drv #(
            .OPEN_DRAIN_OK(OPEN_DRAIN_PORTS[g]),
            .SLEW_OK(SLEW_PORTS[g])
        ) u_drv (
            .bus(cfg_bus.pins),
            .pld_sel_in(pld_sel[g]),
            .pld_val_in(pld_val_in[g]),
            .pld_oe_in(pld_oe_m[g]),
            .alt_en_in(alt_en[g]),
            .alt_val_in(alt_val[g]),
            .force_en_in(force_en[g]),
            .force_oe_in(force_oe[g]),
            .force_val_in(force_val[g]),
            .pin_out(pin_out[g]),
            .pin_oe_n_out(pin_oe_n_out[g]),
            .fast_slew_out(pin_fast_slew_out[g])
        );
    end

    // state update: read data, address latches, pin samples
    always_comb begin
        state_nxt = state_r;
        if (rd_hit) begin
            state_nxt.rdata = 8'h00;
            if (addr_ok) begin
                for (int p = 0; p < NPORT; p++) begin
                    if (port_idx == 3'(p)) begin
                        case (reg_idx)
                            REG_DATA_IN: state_nxt.rdata = pin_in[p];
                            REG_DATA_OUT: state_nxt.rdata = cfg_a[p].data_out;
                            REG_DIRECTION: state_nxt.rdata = cfg_a[p].direction;
                            REG_DRIVE_SELECT: state_nxt.rdata = cfg_a[p].drive_select;
                            REG_MODE_SELECT: state_nxt.rdata = cfg_a[p].mode_select;
                            default: state_nxt.rdata = 8'h00;
                        endcase
                    end
                end
            end
        end
        if (address_latch_strobe_in) begin
            state_nxt.addr_latch = host_ad_in;
        end
        for (int p = 0; p < NPORT; p++) begin
            state_nxt.pld_pins[p] = pin_in[p];
            if (address_latch_strobe_in && ADDR_IN_PORTS[p]) begin
                state_nxt.high_addr[p] = pin_in[p];
            end
        end
        if (cfg_data_port_in) begin
            state_nxt.data_lines = {pin_in[PORT_G], pin_in[PORT_F]};
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign host_rdata_out = state_r.rdata;
    assign pld_pins_out = state_r.pld_pins;
    assign high_addr_out = state_r.high_addr;
    assign host_data_lines_out = state_r.data_lines;
    assign jtag_pins_out = pin_in[PORT_E] & jtag_sel_in;
endmodule : pmc_port_top

/* File: tb_top.sv */
// self-checking bench for the port configuration logic
`timescale 1ns/1ps
module tb_top;
    import pmc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic sel, rd, wr, strobe, narrow, dport, ddrive, rmode, hdrive;
    logic [7:0] addr, wdata, rdata, jsel, jval, joe, jpins;
    logic [15:0] ad, dwr, dlines, rpat, hval, lines, boot;
    logic [NPORT-1:0][7:0] plsel, plval, ploe, hiaddr, tbpin, pins, pout, poe_n, pslew, plpins;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    always #12.5 sys_clk = ~sys_clk;
    assign pins = {lines, tbpin[4:0]};
    pmc_port_top pmc_port_top_inst (.sys_clk_in(sys_clk), .rst_in(rst),
        .io_register_space_in(sel), .host_rd_in(rd), .host_wr_in(wr), .host_addr_in(addr),
        .host_wdata_in(wdata), .host_rdata_out(rdata), .host_ad_in(ad),
        .address_latch_strobe_in(strobe), .host_data_drive_in(ddrive), .host_data_wr_in(dwr),
        .host_data_lines_out(dlines), .cfg_narrow_addr_in(narrow), .cfg_data_port_in(dport),
        .cfg_reset_mode_in(rmode), .cfg_reset_pattern_in(rpat), .cfg_pld_out_sel_in(plsel),
        .pld_val_in(plval), .pld_oe_in(ploe), .pld_pins_out(plpins), .high_addr_out(hiaddr),
        .jtag_sel_in(jsel), .jtag_val_in(jval), .jtag_oe_in(joe), .jtag_pins_out(jpins),
        .pin_in(pins), .pin_out(pout), .pin_oe_n_out(poe_n), .pin_fast_slew_out(pslew));
    pmc_host_model pmc_host_model_inst (.clk_in(sys_clk), .rst_in(rst), .host_drive_in(hdrive),
        .host_val_in(hval), .dev_val_in({pout[6], pout[5]}),
        .dev_oe_n_in({poe_n[6], poe_n[5]}), .lines_out(lines), .boot_cfg_out(boot));
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        {sel, wr, addr, wdata} = {2'b11, a, d};
        @(negedge sys_clk);
        {sel, wr} = 2'b00;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge sys_clk);
        {sel, rd, addr} = {2'b11, a};
        @(negedge sys_clk);
        {sel, rd} = 2'b00;
        check(what, exp, rdata);
    endtask : reg_rd
    task automatic close_out();
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        {sel, rd, wr, strobe, narrow, dport, ddrive, rmode, hdrive} = 9'h000;
        {addr, wdata, jsel, jval, joe} = 40'h0;
        {ad, dwr, rpat, hval} = 64'h0;
        {plsel, plval, ploe, tbpin} = '0;
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        check("idle oe_n", {56{1'b1}}, poe_n);
        check("idle slew", 56'h0, pslew);
        for (int p = 0; p < 7; p++) begin
            for (int r = 1; r < 5; r++) begin
                reg_rd(8'(p * 8 + r), 8'h00, "reset value");
                reg_wr(8'(p * 8 + r), 8'ha5);
                reg_rd(8'(p * 8 + r), (r == 4 && p < 4) ? 8'h00 : (p == 3 ? 8'h05 : 8'ha5),
                    "read back");
                reg_wr(8'(p * 8 + r), 8'h00);
            end
        end
        reg_wr(8'h40, 8'hff);
        reg_rd(8'h40, 8'h00, "unmapped");
        reg_rd(8'h05, 8'h00, "bad index");
        reg_rd(8'h38, 8'h00, "bad port");
        reg_wr(8'h01, 8'h3c);
        reg_wr(8'h02, 8'h0f);
        check("a oe_n", 8'hf0, poe_n[0]);
        check("a out", 8'h0c, pout[0] & 8'h0f);
        tbpin[0] = 8'h96;
        reg_rd(8'h00, 8'h96, "data in");
        check("pld pins", 8'h96, plpins[0]);
        reg_rd(8'h01, 8'h3c, "data out");
        reg_wr(8'h03, 8'h0f);
        check("a open drain", 16'hfc00, {poe_n[0], pout[0] & 8'h0f});
        reg_wr(8'h13, 8'h81);
        check("c slew", 8'h81, pslew[2]);
        // logic output on a, logic enable on b; no logic inputs get direction set
        {plsel[0], plval[0], ploe[0], ploe[1]} = 32'h80808080;
        {plsel[3], plval[3], ploe[3]} = 24'hffffff;
        reg_wr(8'h09, 8'h80);
        check("a logic", 8'h80, pout[0] & ~poe_n[0] & 8'h80);
        check("b enable", 16'h7f80, {poe_n[1], pout[1] & 8'h80});
        check("d logic", 16'hf000, {poe_n[3], pout[3]});
        {plsel[0], plval[0], ploe[0], ploe[1]} = 32'h0;
        {plsel[3], plval[3], ploe[3]} = 24'h0;
        for (int p = 4; p < 7; p++) begin
            reg_wr(8'(p * 8 + 4), 8'hff);
            reg_wr(8'(p * 8 + 2), 8'hff);
        end
        tbpin[0] = 8'h5c;
        ad = 16'h1234;
        strobe = 1'b1;
        @(negedge sys_clk);
        strobe = 1'b0;
        check("addr out", 24'h123434, {pout[6], pout[5], pout[4]});
        check("addr oe_n", 24'h0, {poe_n[6], poe_n[5], poe_n[4]});
        check("high addr", 8'h5c, hiaddr[0]);
        narrow = 1'b1;
        #1 check("narrow", 16'h3030, {pout[5], pout[4]});
        reg_wr(8'h24, 8'h00);
        check("e host io", 16'h0000, {pout[4], poe_n[4]});
        reg_wr(8'h32, 8'h00);
        check("g no dir", 8'hff, poe_n[6]);
        narrow = 1'b0;
        {dport, ddrive, dwr} = {2'b11, 16'hbeef};
        #1 check("data drive", 32'hbeef0000, {pout[6], pout[5], poe_n[6], poe_n[5]});
        {ddrive, hdrive, hval} = {2'b01, 16'h2211};
        repeat (2) @(negedge sys_clk);
        check("data in", 32'h2211ffff, {dlines, poe_n[6], poe_n[5]});
        {hdrive, rmode, rpat} = {2'b01, 16'hc3a5};
        rst = 1'b1;
        #1 check("pattern", 32'hc3a50000, {pout[6], pout[5], poe_n[6], poe_n[5]});
        @(negedge sys_clk);
        rd = 1'b1;
        #1 check("pattern bus", 16'hffff, {poe_n[6], poe_n[5]});
        @(negedge sys_clk);
        rd = 1'b0;
        @(negedge sys_clk);
        rst = 1'b0;
        #1 check("boot cfg", 16'hc3a5, boot);
        check("pattern off", 16'hffff, {poe_n[6], poe_n[5]});
        reg_rd(8'h2a, 8'h00, "cleared");
        {tbpin[4], jsel, jval, joe} = 32'h77ff5aff;
        #1 check("jtag", 24'h775a00, {jpins, pout[4], poe_n[4]});
        close_out();
    end
endmodule : tb_top
